/* File: src/system_interrupt_status_enable.sv */
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "irq_ctrl_regs.svh"

// Overview of operation
// - Each status bit reads 1 while its condition holds, regardless of enable.
// - Software, ready and timer status bits clear when software writes one.
// - Setting the software enable bit sets software status bit 31.
// - Ready bit 30 sets once the device is accessible after reset.
// - Bit 29 mirrors the time-stamp unit pending event; writes ignored.
// - Bit 28 mirrors the switch fabric pending interrupt; writes ignored.
// - Bit 27 mirrors the second port PHY interrupt; writes ignored.
// - Bit 26 mirrors the first port PHY interrupt; writes ignored.
// - Bit 19 sets when the general timer wraps past zero; write one clears.
// - Bit 12 mirrors the general I/O pending interrupt; writes ignored.
// - Internal interrupt line is high while any status and enable pair set.
// - Enable register uses the same bit positions as the status register.
// - Enable bits are read-write and reset to zero.
// - Pin enable bit 8 gates the pin; status keeps working when clear.
// - Read-only bit 12 of configuration shows the internal line state.
// - Hold-off interval withholds the pin, shown by bit 13; bit 14 restarts.
// - Bit 4 selects active-high pin; open-drain pin is always active-low.
module system_interrupt_status_enable #(
    parameter int unsigned HOLDOFF_UNIT_CYCLES = `HOLDOFF_UNIT_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic awvalid,
    output logic awready,
    input wire logic [11:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [11:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic timestamp_unit_event,
    input wire logic fabric_pending_event,
    input wire logic second_port_phy_event,
    input wire logic first_port_phy_event,
    input wire logic pin_io_event,
    input wire logic timer_wrap_pulse,
    output logic irq_line,
    output logic irq_pin_out,
    output logic irq_pin_oe,
    output logic event_irq
);

    localparam logic [13:0] UNIT_LAST = 14'(HOLDOFF_UNIT_CYCLES - 1);

    irq_ctrl_pkg::main_state_t st_r;
    irq_ctrl_pkg::main_state_t st_nxt;

    logic wr_en;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic rd_en;
    logic [11:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    logic [31:0] status_word;
    logic line_now;
    logic holdoff_on;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        case (a)
            `ADDR_INT_STATUS: return 1'b1;
            `ADDR_INT_ENABLE: return 1'b1;
            `ADDR_PIN_CONFIG: return 1'b1;
            `ADDR_EVT_STICKY: return 1'b1;
            `ADDR_EVT_MASK: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    axil_reg_slave u_bus (
        .clk(clk),
        .nrst(nrst),
        .awvalid(awvalid),
        .awready(awready),
        .awaddr(awaddr),
        .wvalid(wvalid),
        .wready(wready),
        .wdata(wdata),
        .wstrb(wstrb),
        .bvalid(bvalid),
        .bready(bready),
        .bresp(bresp),
        .arvalid(arvalid),
        .arready(arready),
        .araddr(araddr),
        .rvalid(rvalid),
        .rready(rready),
        .rdata(rdata),
        .rresp(rresp),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    assign wr_ok = is_mapped(wr_addr);
    assign rd_ok = is_mapped({rd_addr[11:2], 2'b00});

    // ------------------------------------------------------------------
    // Live status word
    // ------------------------------------------------------------------
    // Mirror bits are not stored here, so they drop the moment their source
    // drops and no write can touch them.
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`BIT_SOFTWARE] = st_r.sw_flag;
        status_word[`BIT_READY] = st_r.ready_flag;
        status_word[`BIT_TIMESTAMP] = timestamp_unit_event;
        status_word[`BIT_FABRIC] = fabric_pending_event;
        status_word[`BIT_PHY2] = second_port_phy_event;
        status_word[`BIT_PHY1] = first_port_phy_event;
        status_word[`BIT_TIMER_WRAP] = st_r.wrap_flag;
        status_word[`BIT_PIN_IO] = pin_io_event;
    end

    assign line_now = |(status_word & st_r.enable);
    assign holdoff_on = (st_r.hstate == irq_ctrl_pkg::HOLD_RUN);

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    always_comb begin
        rd_data = 32'h0000_0000;
        case ({rd_addr[11:2], 2'b00})
            `ADDR_INT_STATUS: rd_data = status_word & `IMPL_MASK;
            `ADDR_INT_ENABLE: rd_data = st_r.enable & `IMPL_MASK;
            `ADDR_PIN_CONFIG: begin
                rd_data[`CFG_PUSH_PULL] = st_r.pin_push_pull;
                rd_data[`CFG_POLARITY] = st_r.pin_polarity;
                rd_data[`CFG_PIN_ENABLE] = st_r.pin_enable;
                rd_data[`CFG_MASTER] = st_r.line;
                rd_data[`CFG_HOLDOFF_ACTIVE] = holdoff_on;
                rd_data[`CFG_HOLDOFF_LSB +: 8] = st_r.holdoff_len;
            end
            `ADDR_EVT_STICKY: rd_data = st_r.evt_sticky;
            `ADDR_EVT_MASK: rd_data = st_r.evt_mask;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [31:0] wmask;
        logic [31:0] wbits;
        logic [31:0] clr;
        logic we_sts;
        logic we_en;
        logic we_cfg;
        logic we_emask;
        logic rd_evt;
        logic sw_set;
        logic restart;
        logic pin_assert;
        wmask = strb_mask(wr_strb);
        wbits = wr_data & wmask;
        we_sts = wr_en && (wr_addr == `ADDR_INT_STATUS);
        we_en = wr_en && (wr_addr == `ADDR_INT_ENABLE);
        we_cfg = wr_en && (wr_addr == `ADDR_PIN_CONFIG);
        we_emask = wr_en && (wr_addr == `ADDR_EVT_MASK);
        rd_evt = rd_en && ({rd_addr[11:2], 2'b00} == `ADDR_EVT_STICKY);
        clr = we_sts ? wbits : 32'h0000_0000;
        sw_set = we_en && wbits[`BIT_SOFTWARE] && !st_r.enable[`BIT_SOFTWARE];
        restart = we_cfg && wbits[`CFG_HOLDOFF_RESTART];
        pin_assert = st_r.pin_enable && st_r.line && !holdoff_on;
        st_nxt = st_r;

        if (we_en) begin
            st_nxt.enable = ((st_r.enable & ~wmask) | wbits) & `IMPL_MASK;
        end

        // Only a rising enable raises the request, so a later clear is not
        // undone while software leaves the enable bit set.
        st_nxt.sw_flag = sw_set || (st_r.sw_flag && !clr[`BIT_SOFTWARE]);

        // The first edge after reset release is the first moment the bus can
        // be served, so readiness is announced then.
        if (!st_r.ready_armed) begin
            st_nxt.ready_armed = 1'b1;
            st_nxt.ready_flag = 1'b1;
        end else begin
            st_nxt.ready_flag = st_r.ready_flag && !clr[`BIT_READY];
        end

        st_nxt.wrap_flag = timer_wrap_pulse || (st_r.wrap_flag && !clr[`BIT_TIMER_WRAP]);

        if (we_cfg) begin
            if (wmask[`CFG_PUSH_PULL]) begin
                st_nxt.pin_push_pull = wr_data[`CFG_PUSH_PULL];
            end
            if (wmask[`CFG_POLARITY]) begin
                st_nxt.pin_polarity = wr_data[`CFG_POLARITY];
            end
            if (wmask[`CFG_PIN_ENABLE]) begin
                st_nxt.pin_enable = wr_data[`CFG_PIN_ENABLE];
            end
            if (wmask[`CFG_HOLDOFF_LSB]) begin
                st_nxt.holdoff_len = wr_data[`CFG_HOLDOFF_LSB +: 8];
            end
        end
        if (we_emask) begin
            st_nxt.evt_mask = (st_r.evt_mask & ~wmask) | wbits;
        end
        // A rising status bit in the same cycle as the clearing read survives.
        st_nxt.status_prev = status_word;
        st_nxt.evt_sticky = (status_word & ~st_r.status_prev)
            | (rd_evt ? 32'h0000_0000 : st_r.evt_sticky);
        st_nxt.evt_irq = |(st_nxt.evt_sticky & st_nxt.evt_mask);

        st_nxt.line = line_now;

        // Hold-off starts when the line falls, giving the receiver time to see
        // the pin go inactive before a new assertion. A zero length disables it.
        case (st_r.hstate)
            irq_ctrl_pkg::HOLD_IDLE: begin
                if ((restart || (st_r.line && !line_now)) && st_nxt.holdoff_len != 8'h00) begin
                    st_nxt.hstate = irq_ctrl_pkg::HOLD_RUN;
                    st_nxt.tick_cnt = 14'h0000;
                    st_nxt.units_left = st_nxt.holdoff_len;
                end
            end
            irq_ctrl_pkg::HOLD_RUN: begin
                if (restart) begin
                    st_nxt.tick_cnt = 14'h0000;
                    st_nxt.units_left = st_nxt.holdoff_len;
                    if (st_nxt.holdoff_len == 8'h00) begin
                        st_nxt.hstate = irq_ctrl_pkg::HOLD_IDLE;
                    end
                end else if (st_r.tick_cnt == UNIT_LAST) begin
                    st_nxt.tick_cnt = 14'h0000;
                    st_nxt.units_left = st_r.units_left - 8'h01;
                    if (st_r.units_left <= 8'h01) begin
                        st_nxt.hstate = irq_ctrl_pkg::HOLD_IDLE;
                    end
                end else begin
                    st_nxt.tick_cnt = st_r.tick_cnt + 14'h0001;
                end
            end
            default: begin
                st_nxt.hstate = irq_ctrl_pkg::HOLD_IDLE;
            end
        endcase

        if (!st_r.pin_push_pull) begin
            st_nxt.pin_out = 1'b0;
            st_nxt.pin_oe = pin_assert;
        end else begin
            st_nxt.pin_out = st_r.pin_polarity ? pin_assert : !pin_assert;
            st_nxt.pin_oe = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
            st_r.enable <= `ENABLE_RESET;
            st_r.evt_mask <= `EVT_MASK_RESET;
            st_r.holdoff_len <= `HOLDOFF_LEN_RESET;
            st_r.hstate <= irq_ctrl_pkg::HOLD_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign irq_line = st_r.line;
    assign irq_pin_out = st_r.pin_out;
    assign irq_pin_oe = st_r.pin_oe;
    assign event_irq = st_r.evt_irq;

endmodule

/* File: src/irq_ctrl_regs.svh */
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define ADDR_INT_STATUS 12'h058
`define ADDR_INT_ENABLE 12'h05c
`define ADDR_PIN_CONFIG 12'h100
`define ADDR_EVT_STICKY 12'h104
`define ADDR_EVT_MASK 12'h108

// ----------------------------------------------------------------------
// Status and enable bit positions (shared layout)
// ----------------------------------------------------------------------
`define BIT_SOFTWARE 31
`define BIT_READY 30
`define BIT_TIMESTAMP 29
`define BIT_FABRIC 28
`define BIT_PHY2 27
`define BIT_PHY1 26
`define BIT_TIMER_WRAP 19
`define BIT_PIN_IO 12
`define IMPL_MASK 32'hfc08_1000

// ----------------------------------------------------------------------
// Pin configuration bit positions
// ----------------------------------------------------------------------
`define CFG_PUSH_PULL 0
`define CFG_POLARITY 4
`define CFG_PIN_ENABLE 8
`define CFG_MASTER 12
`define CFG_HOLDOFF_ACTIVE 13
`define CFG_HOLDOFF_RESTART 14
`define CFG_HOLDOFF_LSB 24

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ENABLE_RESET 32'h0000_0000
`define EVT_MASK_RESET 32'h0000_0000
`define HOLDOFF_LEN_RESET 8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define HOLDOFF_UNIT_NS 100000
`define HOLDOFF_UNIT_CYCLES ((`HOLDOFF_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: src/irq_ctrl_pkg.sv */
package irq_ctrl_pkg;

    typedef enum logic [0:0] {
        HOLD_IDLE,
        HOLD_RUN
    } holdoff_state_t;

    typedef struct packed {
        logic aw_got;
        logic [11:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } slave_state_t;

    typedef struct packed {
        logic ready_armed;
        logic sw_flag;
        logic ready_flag;
        logic wrap_flag;
        logic [31:0] enable;
        logic pin_push_pull;
        logic pin_polarity;
        logic pin_enable;
        logic [7:0] holdoff_len;
        holdoff_state_t hstate;
        logic [13:0] tick_cnt;
        logic [7:0] units_left;
        logic line;
        logic [31:0] status_prev;
        logic [31:0] evt_sticky;
        logic [31:0] evt_mask;
        logic pin_out;
        logic pin_oe;
        logic evt_irq;
    } main_state_t;

endpackage

/* File: src/axil_reg_slave.sv */
`timescale 1ns/10ps
`include "irq_ctrl_regs.svh"

module axil_reg_slave (
    input wire logic clk,
    input wire logic nrst,
    input wire logic awvalid,
    output logic awready,
    input wire logic [11:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [11:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic wr_en,
    output logic [11:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic rd_en,
    output logic [11:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);

    irq_ctrl_pkg::slave_state_t st_r;
    irq_ctrl_pkg::slave_state_t st_nxt;

    // A write is committed only once both address and data are held, so the
    // master may offer them in either order.
    assign awready = !st_r.aw_got && !st_r.bvalid;
    assign wready = !st_r.w_got && !st_r.bvalid;
    assign wr_en = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    assign wr_addr = st_r.awaddr;
    assign wr_data = st_r.wdata;
    assign wr_strb = st_r.wstrb;
    assign arready = !st_r.rvalid;
    assign rd_en = arvalid && !st_r.rvalid;
    assign rd_addr = araddr;
    assign bvalid = st_r.bvalid;
    assign bresp = st_r.bresp;
    assign rvalid = st_r.rvalid;
    assign rdata = st_r.rdata;
    assign rresp = st_r.rresp;

    always_comb begin
        st_nxt = st_r;
        if (awvalid && awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = {awaddr[11:2], 2'b00};
        end
        if (wvalid && wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = wdata;
            st_nxt.wstrb = wstrb;
        end
        if (wr_en) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (st_r.bvalid && bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (rd_en) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd_data;
            st_nxt.rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (st_r.rvalid && rready) begin
            st_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule

/* File: sim/sise_chk.sv */
`timescale 1ns/10ps
module sise_chk #(
    parameter int unsigned HOLDOFF_UNIT_CYCLES = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [11:0] awaddr,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [11:0] araddr,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic timestamp_unit_event,
    input wire logic fabric_pending_event,
    input wire logic second_port_phy_event,
    input wire logic first_port_phy_event,
    input wire logic pin_io_event,
    input wire logic irq_line,
    input wire logic irq_pin_out,
    input wire logic irq_pin_oe
);
    // ------------------------------------------------------------------
    // Address capture
    // ------------------------------------------------------------------
    logic [11:0] ar_r;
    logic [11:0] aw_r;
    logic [1:0] age_r;
    logic seen_r;
    logic st_rd;
    logic en_rd;
    logic mapped;
    assign st_rd = ar_r[11:2] == 10'h016;
    assign en_rd = ar_r[11:2] == 10'h017;
    assign mapped = aw_r[11:2] inside {10'h016, 10'h017, 10'h040, 10'h041, 10'h042};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ar_r <= 12'h000;
            aw_r <= 12'h000;
            age_r <= 2'h0;
            seen_r <= 1'b0;
        end else begin
            if (arvalid && arready)
                ar_r <= araddr;
            if (awvalid && awready)
                aw_r <= awaddr;
            if (age_r != 2'h3)
                age_r <= age_r + 2'h1;
            if (rvalid)
                seen_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    a_rsv_status: assert property (rvalid && st_rd |-> (rdata & 32'h03f7_efff) == 32'h0)
        else $error("reserved status bits read nonzero");
    a_rsv_enable: assert property (rvalid && en_rd |-> (rdata & 32'h03f7_efff) == 32'h0)
        else $error("reserved enable bits read nonzero");
    a_mirror_sources: assert property ($rose(rvalid) && st_rd |->
        rdata[29] == $past(timestamp_unit_event) && rdata[28] == $past(fabric_pending_event)
        && rdata[27] == $past(second_port_phy_event) && rdata[26] == $past(first_port_phy_event)
        && rdata[12] == $past(pin_io_event))
        else $error("status mirror differs from source");
    a_ready_first: assert property ($rose(rvalid) && st_rd && !seen_r |-> rdata[30])
        else $error("ready flag missing after reset");
    a_quiet_after_reset: assert property (age_r < 2'h2 |-> !irq_line && !irq_pin_oe)
        else $error("interrupt active right after reset");
    a_pin_needs_line: assert property (irq_pin_oe && !irq_pin_out |-> $past(irq_line))
        else $error("pin asserted without internal line");
    a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    a_unmapped_err: assert property (bvalid && !mapped |-> bresp == 2'h2)
        else $error("unmapped write not refused");

    c_line: cover property ($rose(irq_line));
    c_pin: cover property ($rose(irq_pin_oe));
    c_err: cover property (bvalid && bready && bresp == 2'h2);
endmodule

bind system_interrupt_status_enable sise_chk #(.HOLDOFF_UNIT_CYCLES(HOLDOFF_UNIT_CYCLES)) chk_u (
    .clk, .nrst, .awvalid, .awready, .awaddr, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .timestamp_unit_event, .fabric_pending_event,
    .second_port_phy_event, .first_port_phy_event, .pin_io_event, .irq_line, .irq_pin_out,
    .irq_pin_oe);

/* File: sim/tb.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [4:0] src = 5'h00;
    logic timer_wrap_pulse = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq_line, irq_pin_out, irq_pin_oe, event_irq;
    logic [1:0] bresp, rresp, resp_q;
    logic [31:0] rdata, d;
    int fails = 0;
    int checks_done = 0;
    int pos [5] = '{12, 26, 27, 28, 29};
    always #4 clk = ~clk;

    // Short hold-off unit keeps the interval test to a few dozen cycles.
    system_interrupt_status_enable #(.HOLDOFF_UNIT_CYCLES(16)) dut_u (
        .clk(clk), .nrst(nrst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .timestamp_unit_event(src[4]),
        .fabric_pending_event(src[3]), .second_port_phy_event(src[2]),
        .first_port_phy_event(src[1]), .pin_io_event(src[0]),
        .timer_wrap_pulse(timer_wrap_pulse), .irq_line(irq_line), .irq_pin_out(irq_pin_out),
        .irq_pin_oe(irq_pin_oe), .event_irq(event_irq));

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        bit pa;
        bit pw;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        pa = 1;
        pw = 1;
        while (pa || pw) begin
            @(posedge clk);
            if (pa && awready) begin
                pa = 0;
                awvalid <= 1'b0;
            end
            if (pw && wready) begin
                pw = 0;
                wvalid <= 1'b0;
            end
        end
        // Response is accepted one cycle late so the slave must hold it.
        while (!bvalid) @(posedge clk);
        bready <= 1'b1;
        @(posedge clk);
        bready <= 1'b0;
        resp_q = bresp;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge clk);
        rready <= 1'b1;
        @(posedge clk);
        rready <= 1'b0;
        v = rdata;
        resp_q = rresp;
    endtask

    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        `CHK(nm, e, v)
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_ready;
        rdchk("status after reset", 12'h058, 32'h4000_0000);
        wr(12'h058, 32'h0000_0000);
        rdchk("status zero write", 12'h058, 32'h4000_0000);
        wr(12'h058, 32'hffff_ffff);
        rdchk("status cleared", 12'h058, 32'h0000_0000);
        rdchk("enable reset", 12'h05c, 32'h0000_0000);
    endtask

    task automatic t_mirror;
        for (int i = 0; i < 5; i++) begin
            src <= 5'h01 << i;
            cyc(2);
            rdchk("mirror set", 12'h058, 32'h1 << pos[i]);
            wr(12'h058, 32'h1 << pos[i]);
            rdchk("mirror kept", 12'h058, 32'h1 << pos[i]);
            src <= 5'h00;
            cyc(2);
            rdchk("mirror clear", 12'h058, 32'h0);
        end
    endtask

    task automatic t_timer;
        timer_wrap_pulse <= 1'b1;
        cyc(1);
        timer_wrap_pulse <= 1'b0;
        cyc(2);
        rdchk("timer wrap", 12'h058, 32'h0008_0000);
        wr(12'h058, 32'h0008_0000);
        rdchk("timer cleared", 12'h058, 32'h0);
    endtask

    task automatic t_enable;
        wr(12'h05c, 32'hffff_ffff);
        rdchk("enable layout", 12'h05c, 32'hfc08_1000);
        rdchk("software flag", 12'h058, 32'h8000_0000);
        `CHK("line on", 1'b1, irq_line)
        wr(12'h058, 32'h8000_0000);
        cyc(2);
        `CHK("line off", 1'b0, irq_line)
        wr(12'h05c, 32'h0400_0000);
        src <= 5'h02;
        cyc(3);
        `CHK("line by source", 1'b1, irq_line)
        wr(12'h05c, 32'h0);
        cyc(2);
        `CHK("line masked", 1'b0, irq_line)
        src <= 5'h00;
    endtask

    task automatic t_pin;
        src <= 5'h01;
        wr(12'h05c, 32'h0000_1000);
        wr(12'h100, 32'h0000_0110);
        cyc(3);
        `CHK("open drain drive", 2'b10, {irq_pin_oe, irq_pin_out})
        rdchk("config line", 12'h100, 32'h0000_1110);
        wr(12'h100, 32'h0);
        cyc(3);
        `CHK("pin gated", 3'b100, {irq_line, irq_pin_oe, irq_pin_out})
        wr(12'h100, 32'h0100_4101);
        rdchk("holdoff running", 12'h100, 32'h0100_3101);
        `CHK("pin withheld", 2'b11, {irq_pin_oe, irq_pin_out})
        cyc(40);
        `CHK("push pull low", 2'b10, {irq_pin_oe, irq_pin_out})
        wr(12'h100, 32'h0000_0111);
        cyc(3);
        `CHK("active high", 2'b11, {irq_pin_oe, irq_pin_out})
        wr(12'h100, 32'h0);
        wr(12'h05c, 32'h0);
        src <= 5'h00;
    endtask

    task automatic t_evt;
        wr(12'h108, 32'h0400_0000);
        rd(12'h104, d);
        for (int m = 1; m >= 0; m--) begin
            src <= 5'h02;
            cyc(1);
            src <= 5'h00;
            cyc(3);
            `CHK("event line", m[0], event_irq)
            rdchk("event sticky", 12'h104, 32'h0400_0000);
            cyc(2);
            `CHK("event cleared", 1'b0, event_irq)
            wr(12'h108, 32'h0);
        end
    endtask

    task automatic t_bad;
        wr(12'h0a0, 32'hffff_ffff);
        `CHK("unmapped write", 2'h2, resp_q)
        rd(12'h0a0, d);
        `CHK("unmapped read", 34'h2_0000_0000, {resp_q, d})
    endtask

    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    task automatic end_sim;
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        cyc(2);
        t_ready();
        t_mirror();
        t_timer();
        t_enable();
        t_pin();
        t_evt();
        t_bad();
        end_sim();
    end

    // Whole run needs a few hundred cycles; this margin only catches a hang.
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        end_sim();
    end
endmodule
